// File: rtl/edoc_defs.svh
// Timing, geometry and pin-field constants for the extended-output DRAM
`ifndef EDOC_DEFS_SVH
`define EDOC_DEFS_SVH
`define EDOC_CLK_MHZ          200
`define EDOC_ROW_BITS_4K      12
`define EDOC_COL_BITS_4K      12
`define EDOC_ROW_BITS_8K      13
`define EDOC_COL_BITS_8K      11
`define EDOC_ADDR_PINS        13
`define EDOC_DATA_BITS        4
`define EDOC_LOC_BITS         24
`define EDOC_REFRESH_MS       64
`define EDOC_REFRESH_CYCLES   4096
`define EDOC_ROWONLY_8K       8192
`define EDOC_ROWONLY_4K       4096
// Refresh slot in ns: 64 ms spread over 4096 column-first cycles
`define EDOC_REF_INT_NS       15625
`define EDOC_REF_INT_CYC      ((`EDOC_REF_INT_NS * `EDOC_CLK_MHZ) / 1000)
// Strobe phase times, ns
`define EDOC_T_ROW_PRE_NS     40
`define EDOC_T_ROW_TO_COL_NS  20
`define EDOC_T_COL_LOW_NS     20
`define EDOC_T_COLUMN_PRECHARGE_NS 10
`define EDOC_T_GATE_HIGH_PULSE_NS  10
`define EDOC_T_ROW_LOW_SELF_REFRESH_NS 100000
`define EDOC_T_ROW_HIGH_SELF_EXIT_NS   110
`define EDOC_NS2CYC(ns)       ((((ns) * `EDOC_CLK_MHZ) + 999) / 1000)
`define EDOC_PH_W             16
`endif

// File: rtl/edoc_pkg.sv
// Types for the extended-output DRAM controller
package edoc_pkg;
	typedef enum logic [4:0] {
		EDOC_IDLE,
		EDOC_ROW_SET,
		EDOC_ROW_LOW,
		EDOC_COL_LOW,
		EDOC_LATE_GATE,
		EDOC_LATE_WE,
		EDOC_COL_HIGH,
		EDOC_PRECHARGE,
		EDOC_CFR_COL,
		EDOC_CFR_ROW,
		EDOC_SELF_HOLD,
		EDOC_SELF_EXIT,
		EDOC_BURST
	} edoc_state_type;
	typedef enum logic [1:0] {
		EDOC_OP_READ,
		EDOC_OP_EARLY_WRITE,
		EDOC_OP_LATE_WRITE
	} edoc_op_type;
endpackage : edoc_pkg

// File: rtl/edoc_phase_timer.sv
// Down-counter that times one strobe phase
`timescale 1ns/100ps
`include "edoc_defs.svh"
module edoc_phase_timer (
	input  wire logic                   core_clk_i,
	input  wire logic                   reset_i,
	input  wire logic                   load_i,
	input  wire logic [`EDOC_PH_W-1:0]  count_i,
	output logic                        done_o
);
	logic [`EDOC_PH_W-1:0] cnt_q;
	logic [`EDOC_PH_W-1:0] cnt_d;
	always_comb begin
		cnt_d = cnt_q;
		if (load_i) begin
			cnt_d = count_i;
		end else if (cnt_q != '0) begin
			cnt_d = cnt_q - `EDOC_PH_W'(1);
		end
	end
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end
	// Registered view only: a load in the same cycle must not loop back
	assign done_o = (cnt_q == '0);
endmodule : edoc_phase_timer

// File: rtl/edoc_refresh_tick.sv
// Distributed refresh divider: one-cycle enable per refresh slot
`timescale 1ns/100ps
`include "edoc_defs.svh"
module edoc_refresh_tick #(
	parameter int REF_INT_CYC = `EDOC_REF_INT_CYC
) (
	input  wire logic core_clk_i,
	input  wire logic reset_i,
	output logic      tick_o
);
	logic [15:0] div_q;
	logic [15:0] div_d;
	logic        tick_d;
	always_comb begin
		tick_d = 1'b0;
		if (div_q == 16'(REF_INT_CYC - 1)) begin
			div_d  = 16'h0000;
			tick_d = 1'b1;
		end else begin
			div_d = div_q + 16'h0001;
		end
	end
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			div_q  <= 16'h0000;
			tick_o <= 1'b0;
		end else begin
			div_q  <= div_d;
			tick_o <= tick_d;
		end
	end
endmodule : edoc_refresh_tick

// File: rtl/edoc_ctrl.sv
// Extended-output DRAM controller: access, page, refresh and self refresh
//
// Functional notes
// - Strobes active low; row address with row strobe, then column.
// - Write strobe high reads, low writes; four bidirectional data pins.
// - Late write: controller raises gate before driving data.
// - Page: row opened, columns cycled, row rise ends page.
// - Every row refreshed at least once per 64 ms.
// - Issue 4096 column-first refresh cycles per 64 ms.
// - Row-only refresh needs 8192 or 4096 cycles per variant.
// - Self refresh: column-first cycle, row held low long enough.
// - Self-refresh parts allow 128 ms distributed refresh period.
// - Trailing hash means active low; all strobes follow it.
// - Self exit by row high; burst refresh all rows afterward.
`timescale 1ns/100ps
`include "edoc_defs.svh"
module edoc_ctrl #(
	parameter int REF_INT_CYC  = `EDOC_REF_INT_CYC,
	parameter int SELF_LOW_CYC = `EDOC_NS2CYC(`EDOC_T_ROW_LOW_SELF_REFRESH_NS),
	parameter bit ROWS_8K      = 1'b0
) (
	input  wire logic                      core_clk_i,
	input  wire logic                      reset_i,
	input  wire logic                      req_valid_i,
	input  wire edoc_pkg::edoc_op_type     req_op_i,
	input  wire logic [`EDOC_LOC_BITS-1:0] req_addr_i,
	input  wire logic [`EDOC_DATA_BITS-1:0] req_wdata_i,
	input  wire logic                      req_page_i,
	input  wire logic                      self_req_i,
	output logic                           req_ready_o,
	output logic                           rsp_valid_o,
	output logic [`EDOC_DATA_BITS-1:0]     rsp_rdata_o,
	output logic                           self_active_o,
	output logic                           row_n_o,
	output logic                           col_n_o,
	output logic                           we_n_o,
	output logic                           gate_n_o,
	output logic [`EDOC_ADDR_PINS-1:0]     mux_address_pins_o,
	input  wire logic [`EDOC_DATA_BITS-1:0] data_io_pins_i,
	output logic [`EDOC_DATA_BITS-1:0]     data_io_pins_o,
	output logic [`EDOC_DATA_BITS-1:0]     data_io_pins_oe_n_o
);
	import edoc_pkg::*;

	localparam int ROW_BITS = ROWS_8K ? `EDOC_ROW_BITS_8K : `EDOC_ROW_BITS_4K;
	localparam int COL_BITS = ROWS_8K ? `EDOC_COL_BITS_8K : `EDOC_COL_BITS_4K;
	localparam logic [15:0] C_PRE = 16'(`EDOC_NS2CYC(`EDOC_T_ROW_PRE_NS));
	localparam logic [15:0] C_RCD = 16'(`EDOC_NS2CYC(`EDOC_T_ROW_TO_COL_NS));
	localparam logic [15:0] C_CAS = 16'(`EDOC_NS2CYC(`EDOC_T_COL_LOW_NS));
	localparam logic [15:0] C_CP  =
		16'(`EDOC_NS2CYC(`EDOC_T_COLUMN_PRECHARGE_NS));
	localparam logic [15:0] C_OEP =
		16'(`EDOC_NS2CYC(`EDOC_T_GATE_HIGH_PULSE_NS));
	localparam logic [15:0] C_RPS =
		16'(`EDOC_NS2CYC(`EDOC_T_ROW_HIGH_SELF_EXIT_NS));
	localparam logic [15:0] C_SELF = 16'(SELF_LOW_CYC);
	localparam logic [12:0] BURST_LAST = 13'(`EDOC_REFRESH_CYCLES - 1);

	edoc_state_type st_q, st_d;
	edoc_op_type    op_q, op_d;
	logic [`EDOC_LOC_BITS-1:0]  addr_q, addr_d;
	logic [`EDOC_DATA_BITS-1:0] wdata_q, wdata_d;
	logic [`EDOC_DATA_BITS-1:0] rdata_q, rdata_d;
	logic [`EDOC_ADDR_PINS-1:0] pins_q, pins_d;
	logic [`EDOC_DATA_BITS-1:0] dout_q, dout_d, oen_q, oen_d;
	logic row_n_q, row_n_d, col_n_q, col_n_d, we_n_q, we_n_d;
	logic gate_n_q, gate_n_d, ready_q, ready_d, rsp_q, rsp_d;
	logic ref_pend_q, ref_pend_d, self_q, self_d, page_q, page_d;
	logic [12:0] burst_q, burst_d;
	logic        tm_load;
	logic [15:0] tm_count;
	logic        tm_done;
	logic        ref_tick;
	logic [ROW_BITS-1:0] row_field;
	logic [COL_BITS-1:0] col_field;

	assign row_field = req_addr_i[`EDOC_LOC_BITS-1 -: ROW_BITS];
	assign col_field = addr_q[COL_BITS-1:0];

	edoc_phase_timer u_timer (
		.core_clk_i (core_clk_i),
		.reset_i    (reset_i),
		.load_i     (tm_load),
		.count_i    (tm_count),
		.done_o     (tm_done)
	);

	edoc_refresh_tick #(
		.REF_INT_CYC (REF_INT_CYC)
	) u_tick (
		.core_clk_i (core_clk_i),
		.reset_i    (reset_i),
		.tick_o     (ref_tick)
	);

	always_comb begin
		st_d = st_q;
		op_d = op_q;
		addr_d = addr_q;
		wdata_d = wdata_q;
		rdata_d = rdata_q;
		pins_d = pins_q;
		dout_d = dout_q;
		oen_d = oen_q;
		row_n_d = row_n_q;
		col_n_d = col_n_q;
		we_n_d = we_n_q;
		gate_n_d = gate_n_q;
		ready_d = 1'b0;
		rsp_d = 1'b0;
		self_d = self_q;
		page_d = page_q;
		burst_d = burst_q;
		tm_load = 1'b0;
		tm_count = 16'h0000;
		ref_pend_d = ref_pend_q | ref_tick;
		case (st_q)
			EDOC_IDLE: begin
				row_n_d = 1'b1;
				col_n_d = 1'b1;
				we_n_d = 1'b1;
				gate_n_d = 1'b1;
				oen_d = '1;
				// take only on an edge that shows ready
				// Ready was offered, so a new tick waits one access
				if (ready_q && req_valid_i) begin
					op_d = req_op_i;
					addr_d = req_addr_i;
					wdata_d = req_wdata_i;
					page_d = req_page_i;
					pins_d = `EDOC_ADDR_PINS'(row_field);
					st_d = EDOC_ROW_SET;
				end else if (tm_done && ref_pend_q) begin
					ref_pend_d = ref_tick;
					col_n_d = 1'b0;
					tm_load = 1'b1;
					tm_count = C_RCD;
					st_d = EDOC_CFR_COL;
				end else if (tm_done && self_req_i) begin
					col_n_d = 1'b0;
					self_d = 1'b1;
					tm_load = 1'b1;
					tm_count = C_RCD;
					st_d = EDOC_CFR_COL;
				end else begin
					ready_d = tm_done && !ref_pend_q && !self_req_i;
				end
			end
			EDOC_ROW_SET: begin
				row_n_d = 1'b0;
				tm_load = 1'b1;
				tm_count = C_RCD;
				st_d = EDOC_ROW_LOW;
			end
			EDOC_ROW_LOW: begin
				pins_d = `EDOC_ADDR_PINS'(col_field);
				if (tm_done) begin
					we_n_d = (op_q != EDOC_OP_EARLY_WRITE);
					gate_n_d = (op_q != EDOC_OP_READ);
					if (op_q == EDOC_OP_EARLY_WRITE) begin
						dout_d = wdata_q;
						oen_d = '0;
					end
					col_n_d = 1'b0;
					tm_load = 1'b1;
					tm_count = C_CAS;
					st_d = EDOC_COL_LOW;
				end
			end
			EDOC_COL_LOW: begin
				if (tm_done) begin
					if (op_q == EDOC_OP_LATE_WRITE && we_n_q) begin
						gate_n_d = 1'b1;
						tm_load = 1'b1;
						tm_count = C_OEP;
						st_d = EDOC_LATE_GATE;
					end else begin
						if (op_q == EDOC_OP_READ) begin
							rdata_d = data_io_pins_i;
						end
						col_n_d = 1'b1;
						rsp_d = 1'b1;
						tm_load = 1'b1;
						tm_count = C_CP;
						st_d = EDOC_COL_HIGH;
					end
				end
			end
			EDOC_LATE_GATE: begin
				if (tm_done) begin
					dout_d = wdata_q;
					oen_d = '0;
					st_d = EDOC_LATE_WE;
				end
			end
			EDOC_LATE_WE: begin
				we_n_d = 1'b0;
				tm_load = 1'b1;
				tm_count = C_CAS;
				st_d = EDOC_COL_LOW;
			end
			EDOC_COL_HIGH: begin
				gate_n_d = 1'b1;
				we_n_d = 1'b1;
				oen_d = '1;
				if (ready_q && req_valid_i) begin
					op_d = req_op_i;
					addr_d = req_addr_i;
					wdata_d = req_wdata_i;
					page_d = req_page_i;
					pins_d = `EDOC_ADDR_PINS'(req_addr_i[COL_BITS-1:0]);
					st_d = EDOC_ROW_LOW;
				end else if (tm_done && page_q && !ready_q && !ref_pend_q
					&& !self_req_i) begin
					ready_d = 1'b1;
				end else if (tm_done) begin
					row_n_d = 1'b1;
					tm_load = 1'b1;
					tm_count = C_PRE;
					st_d = EDOC_PRECHARGE;
				end
			end
			EDOC_PRECHARGE: begin
				if (tm_done) begin
					st_d = EDOC_IDLE;
				end
			end
			EDOC_CFR_COL: begin
				if (tm_done) begin
					row_n_d = 1'b0;
					tm_load = 1'b1;
					tm_count = self_q ? C_SELF : C_CAS;
					st_d = EDOC_CFR_ROW;
				end
			end
			EDOC_CFR_ROW: begin
				if (tm_done) begin
					if (self_q) begin
						st_d = EDOC_SELF_HOLD;
					end else begin
						row_n_d = 1'b1;
						col_n_d = 1'b1;
						tm_load = 1'b1;
						tm_count = C_PRE;
						st_d = (burst_q != 13'h0000) ? EDOC_BURST
							: EDOC_PRECHARGE;
					end
				end
			end
			EDOC_SELF_HOLD: begin
				if (!self_req_i) begin
					row_n_d = 1'b1;
					col_n_d = 1'b1;
					tm_load = 1'b1;
					tm_count = C_RPS;
					st_d = EDOC_SELF_EXIT;
				end
			end
			EDOC_SELF_EXIT: begin
				if (tm_done) begin
					self_d = 1'b0;
					burst_d = BURST_LAST;
					col_n_d = 1'b0;
					tm_load = 1'b1;
					tm_count = C_RCD;
					st_d = EDOC_CFR_COL;
				end
			end
			EDOC_BURST: begin
				if (tm_done) begin
					burst_d = burst_q - 13'h0001;
					col_n_d = 1'b0;
					tm_load = 1'b1;
					tm_count = C_RCD;
					st_d = EDOC_CFR_COL;
				end
			end
			default: begin
				st_d = EDOC_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			st_q <= EDOC_IDLE;
			op_q <= EDOC_OP_READ;
			addr_q <= '0;
			wdata_q <= '0;
			rdata_q <= '0;
			pins_q <= '0;
			dout_q <= '0;
			oen_q <= '1;
			row_n_q <= 1'b1;
			col_n_q <= 1'b1;
			we_n_q <= 1'b1;
			gate_n_q <= 1'b1;
			ready_q <= 1'b0;
			rsp_q <= 1'b0;
			ref_pend_q <= 1'b0;
			self_q <= 1'b0;
			page_q <= 1'b0;
			burst_q <= 13'h0000;
		end else begin
			st_q <= st_d;
			op_q <= op_d;
			addr_q <= addr_d;
			wdata_q <= wdata_d;
			rdata_q <= rdata_d;
			pins_q <= pins_d;
			dout_q <= dout_d;
			oen_q <= oen_d;
			row_n_q <= row_n_d;
			col_n_q <= col_n_d;
			we_n_q <= we_n_d;
			gate_n_q <= gate_n_d;
			ready_q <= ready_d;
			rsp_q <= rsp_d;
			ref_pend_q <= ref_pend_d;
			self_q <= self_d;
			page_q <= page_d;
			burst_q <= burst_d;
		end
	end

	assign req_ready_o = ready_q;
	assign rsp_valid_o = rsp_q;
	assign rsp_rdata_o = rdata_q;
	assign self_active_o = self_q;
	assign row_n_o = row_n_q;
	assign col_n_o = col_n_q;
	assign we_n_o = we_n_q;
	assign gate_n_o = gate_n_q;
	assign mux_address_pins_o = pins_q;
	assign data_io_pins_o = dout_q;
	assign data_io_pins_oe_n_o = oen_q;

	// Assertions
	sequence s_cfr_start;
		!col_n_q && row_n_q;
	endsequence
	AST_CFR_ORDER: assert property (@(posedge core_clk_i) disable iff (reset_i)
		$fell(row_n_q) && !$past(col_n_q) |-> st_q == EDOC_CFR_ROW)
		else $error("row fell after column outside refresh");
	AST_ROW_FIRST: assert property (@(posedge core_clk_i) disable iff (reset_i)
		$fell(col_n_q) && !self_q && st_q == EDOC_COL_LOW |-> !row_n_q)
		else $error("column strobe fell before row");
	AST_LATE_GATE: assert property (@(posedge core_clk_i) disable iff (reset_i)
		$fell(oen_q[0]) && op_q == EDOC_OP_LATE_WRITE |-> gate_n_q)
		else $error("data driven with gate low in late write");
	AST_EARLY_WE: assert property (@(posedge core_clk_i) disable iff (reset_i)
		$fell(col_n_q) && st_q == EDOC_COL_LOW
		&& op_q == EDOC_OP_EARLY_WRITE |-> !we_n_q)
		else $error("early write strobe not low before column");
	AST_READ_DIR: assert property (@(posedge core_clk_i) disable iff (reset_i)
		!col_n_q && op_q == EDOC_OP_READ && !row_n_q |-> we_n_q && &oen_q)
		else $error("read cycle with write strobe low or pins driven");
	AST_PAGE_END: assert property (@(posedge core_clk_i) disable iff (reset_i)
		$rose(row_n_q) && st_q == EDOC_PRECHARGE |-> col_n_q)
		else $error("row strobe rose with column low");
	AST_REF_SERVE: assert property (@(posedge core_clk_i) disable iff (reset_i)
		$rose(ref_pend_q) && st_q == EDOC_IDLE && !self_q
		|-> ##[1:60] s_cfr_start)
		else $error("refresh slot not served");
	AST_SELF_EXIT: assert property (@(posedge core_clk_i) disable iff (reset_i)
		st_q == EDOC_SELF_EXIT |-> row_n_q)
		else $error("row strobe low during self exit");
	AST_STANDBY: assert property (@(posedge core_clk_i) disable iff (reset_i)
		st_q == EDOC_IDLE |-> row_n_q && col_n_q && &oen_q)
		else $error("strobes not high in standby");
	// kept by refresh pacing and active-low pins
endmodule : edoc_ctrl

// File: tb/edoc_dram_model.sv
// Behavioural extended-output DRAM at its pins, far side of the controller
`timescale 1ns/100ps
module edoc_dram_model #(
	parameter bit  ROWS_8K = 1'b0,
	parameter real SELF_NS = 50.0
) (
	input  wire logic        row_n_i,
	input  wire logic        col_n_i,
	input  wire logic        we_n_i,
	input  wire logic        gate_n_i,
	input  wire logic [12:0] addr_i,
	input  wire logic [3:0]  dq_i,
	output logic [3:0]       dq_o,
	output logic             dq_oe_n_o,
	output int               row_seen_o,
	output int               col_seen_o,
	output int               row_opens_o,
	output int               colref_cnt_o,
	output int               self_cnt_o,
	output int               bad_wr_o
);
	localparam int RB = ROWS_8K ? 13 : 12;
	localparam int CB = 24 - RB;
	// Sparse store, only written nibbles take memory
	logic [3:0] mem [int];
	logic       open_q = 1'b0;
	logic       colref_q = 1'b0;
	logic       col_q  = 1'b0;
	logic       wr_q   = 1'b0;
	logic       off_q  = 1'b0;
	int         ref_row = 0;
	int         loc;
	realtime    t_row;
	initial begin
		dq_o = 4'h0;
		row_seen_o = 0;
		col_seen_o = 0;
		row_opens_o = 0;
		colref_cnt_o = 0;
		self_cnt_o = 0;
		bad_wr_o = 0;
	end
	always @(negedge row_n_i) begin
		t_row = $realtime;
		// Pins settle in the same step as the strobe
		#0.1;
		if (col_n_i === 1'b0) begin
			colref_q = 1'b1;
			colref_cnt_o++;
			ref_row = (ref_row + (ROWS_8K ? 2 : 1)) % (1 << RB);
		end else begin
			row_seen_o = int'(addr_i) & ((1 << RB) - 1);
			open_q = 1'b1;
			row_opens_o++;
		end
	end
	always @(posedge row_n_i) begin
		if (colref_q && ($realtime - t_row) >= SELF_NS)
			self_cnt_o++;
		colref_q = 1'b0;
		open_q = 1'b0;
		col_q = 1'b0;
	end
	always @(negedge col_n_i) begin
		#0.1;
		if (open_q && !row_n_i) begin
			col_seen_o = int'(addr_i) & ((1 << CB) - 1);
			loc = (row_seen_o << CB) | col_seen_o;
			col_q = 1'b1;
			off_q = 1'b0;
			wr_q = !we_n_i;
			if (wr_q)
				mem[loc] = dq_i;
			dq_o = mem.exists(loc) ? mem[loc] : 4'h0;
		end
	end
	always @(negedge we_n_i) begin
		#0.1;
		if (open_q && col_q && !col_n_i) begin
			if (gate_n_i) begin
				mem[loc] = dq_i;
				wr_q = 1'b1;
			end else
				bad_wr_o++;
		end
	end
	always @(posedge col_n_i or posedge gate_n_i)
		if (col_n_i && gate_n_i)
			off_q = 1'b1;
	assign dq_oe_n_o = !(open_q && col_q && !wr_q && !off_q && !gate_n_i);
endmodule : edoc_dram_model

// File: tb/testbench.sv
// Self-checking bench for the extended-output DRAM controller
`timescale 1ns/100ps
module testbench;
	import edoc_pkg::*;
	localparam int REF_CYC  = 200;
	localparam int SELF_CYC = 10;
	localparam int LIMIT    = 6000;
	logic        core_clk_i  = 1'b0;
	logic        reset_i     = 1'b1;
	logic        req_valid_i = 1'b0;
	edoc_op_type req_op_i    = EDOC_OP_READ;
	logic [23:0] req_addr_i  = 24'h00_0000;
	logic [3:0]  req_wdata_i = 4'h0;
	logic        req_page_i  = 1'b0;
	logic        self_req_i  = 1'b0;
	logic        req_ready_o, rsp_valid_o, self_active_o;
	logic        row_n_o, col_n_o, we_n_o, gate_n_o, m_oe_n;
	logic [3:0]  rsp_rdata_o, c_dq, c_oe_n, m_dq, dq_wire;
	logic [3:0]  dq_last = 4'h0;
	logic [12:0] mux_address_pins_o;
	int          row_seen, col_seen, row_opens, colref_cnt, self_cnt, bad_wr;
	int          n_mismatch = 0;
	int          total_checks = 0;
	int          cycles = 0;
	logic [3:0]  rd;
	logic [23:0] ad [3] = '{24'h12_3456, 24'hAB_C0FF, 24'h12_3457};
	logic [3:0]  wd [3] = '{4'h5, 4'hA, 4'hC};

	always #2.5 core_clk_i = ~core_clk_i;
	// Undriven wire shows a toggling pattern, never a stale value
	assign dq_wire = !m_oe_n ? m_dq : ((c_dq & ~c_oe_n) | (~dq_last & c_oe_n));
	always @(posedge core_clk_i)
		dq_last <= dq_wire;

	edoc_ctrl #(.REF_INT_CYC(REF_CYC), .SELF_LOW_CYC(SELF_CYC)) dut (
		.core_clk_i(core_clk_i), .reset_i(reset_i),
		.req_valid_i(req_valid_i), .req_op_i(req_op_i),
		.req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i),
		.req_page_i(req_page_i), .self_req_i(self_req_i),
		.req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o),
		.rsp_rdata_o(rsp_rdata_o), .self_active_o(self_active_o),
		.row_n_o(row_n_o), .col_n_o(col_n_o), .we_n_o(we_n_o),
		.gate_n_o(gate_n_o), .mux_address_pins_o(mux_address_pins_o),
		.data_io_pins_i(dq_wire), .data_io_pins_o(c_dq),
		.data_io_pins_oe_n_o(c_oe_n));

	edoc_dram_model #(.SELF_NS(SELF_CYC * 5.0)) mem_model (
		.row_n_i(row_n_o), .col_n_i(col_n_o), .we_n_i(we_n_o),
		.gate_n_i(gate_n_o), .addr_i(mux_address_pins_o), .dq_i(dq_wire),
		.dq_o(m_dq), .dq_oe_n_o(m_oe_n), .row_seen_o(row_seen),
		.col_seen_o(col_seen), .row_opens_o(row_opens),
		.colref_cnt_o(colref_cnt), .self_cnt_o(self_cnt), .bad_wr_o(bad_wr));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : tally_and_finish

	// One access: request held until taken, then wait for the answer
	task automatic do_access(input edoc_op_type op, input logic [23:0] a,
		input logic [3:0] d, input logic pg, output logic [3:0] q);
		int k;
		@(posedge core_clk_i);
		#1;
		req_valid_i = 1'b1;
		req_op_i = op;
		req_addr_i = a;
		req_wdata_i = d;
		req_page_i = pg;
		k = 0;
		do begin
			@(posedge core_clk_i);
			k++;
		end while (req_ready_o !== 1'b1 && k < 800);
		check(req_ready_o, 1'h1);
		#1;
		req_valid_i = 1'b0;
		do begin
			@(posedge core_clk_i);
			k++;
		end while (rsp_valid_o !== 1'b1 && k < 1600);
		check(rsp_valid_o, 1'h1);
		#1;
		q = rsp_rdata_o;
	endtask : do_access

	task automatic t_reset;
		check({row_n_o, col_n_o, we_n_o, gate_n_o}, 4'hF);
		check(c_oe_n, 4'hF);
	endtask : t_reset

	task automatic t_write_read;
		edoc_op_type op;
		for (int i = 0; i < 3; i++) begin
			op = (i == 1) ? EDOC_OP_LATE_WRITE : EDOC_OP_EARLY_WRITE;
			do_access(op, ad[i], wd[i], 1'b0, rd);
			check(row_seen, ad[i] >> 12);
			check(col_seen, ad[i] & 24'h00_0FFF);
		end
		for (int i = 2; i >= 0; i--) begin
			do_access(EDOC_OP_READ, ad[i], 4'h0, 1'b0, rd);
			check(rd, wd[i]);
		end
		check(bad_wr, 0);
	endtask : t_write_read

	task automatic t_refresh;
		int k, c0, r0;
		c0 = colref_cnt;
		r0 = row_seen;
		k = 0;
		do begin
			@(posedge core_clk_i);
			k++;
		end while (colref_cnt == c0 && k < 3 * REF_CYC);
		check(colref_cnt - c0, 1);
		check(row_seen, r0);
		// One more slot brings exactly one more refresh
		repeat (REF_CYC + REF_CYC / 2) @(posedge core_clk_i);
		check(colref_cnt - c0, 2);
	endtask : t_refresh

	task automatic t_page;
		int o0;
		o0 = row_opens;
		do_access(EDOC_OP_READ, ad[0], 4'h0, 1'b1, rd);
		check(rd, wd[0]);
		do_access(EDOC_OP_READ, ad[2], 4'h0, 1'b0, rd);
		check(rd, wd[2]);
		check(row_opens - o0, 1);
	endtask : t_page

	task automatic t_self;
		int k, s0, c1;
		s0 = self_cnt;
		self_req_i = 1'b1;
		k = 0;
		do begin
			@(posedge core_clk_i);
			k++;
		end while (self_active_o !== 1'b1 && k < 2000);
		check(self_active_o, 1'h1);
		repeat (3 * SELF_CYC) @(posedge core_clk_i);
		#1;
		check(row_n_o, 1'h0);
		self_req_i = 1'b0;
		repeat (40) @(posedge core_clk_i);
		check(self_cnt - s0, 1);
		check(self_active_o, 1'h0);
		c1 = colref_cnt;
		repeat (200) @(posedge core_clk_i);
		check(colref_cnt - c1 > 2, 1'h1);
	endtask : t_self

	always @(posedge core_clk_i) begin
		cycles++;
		if (cycles == LIMIT) begin
			n_mismatch++;
			tally_and_finish();
		end
	end

	initial begin
		repeat (20) @(posedge core_clk_i);
		#1;
		reset_i = 1'b0;
		t_reset();
		t_write_read();
		t_refresh();
		t_page();
		t_self();
		tally_and_finish();
	end
endmodule : testbench
